// ===== emr_pkg.sv
// Shared sizes, field positions and reset values of the embedded RAM block
package emr_pkg;

    // Cell array: 512 cells of one data byte plus one parity bit
    localparam int CELL_COUNT = 512;
    localparam int CELL_W = 9;
    localparam int BYTE_W = 8;
    localparam int PARITY_POS = 8;

    // Narrow geometry 512 x 9, wide geometry 256 x 18
    localparam int ADDR_W = 9;
    localparam int WIDE_ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int PAR_W = 2;
    localparam int WORD_W = 18;

    // Two symmetric ports per block
    localparam int PORT_COUNT = 2;

    // Buffer depth and derived widths
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 18;
    localparam int COUNT_W = 6;

    // Reset values of the read registers
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [PAR_W-1:0] PAR_RESET = 2'h0;

    // Clock enable is active low: this level stops the port
    localparam logic CE_IDLE = 1'b1;

endpackage

// ===== emr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Connection between the memory block and the user logic beside it
interface emr_link_if;

    // Geometry select: 1 gives 256 x 18, 0 gives 512 x 9
    logic wide_mode;
    // Per port controls, identical for both ports
    logic [emr_pkg::PORT_COUNT-1:0] clock_enable_n;
    logic [emr_pkg::PORT_COUNT-1:0] write_port_enable;
    logic [emr_pkg::PORT_COUNT-1:0] output_enable;
    logic [emr_pkg::PORT_COUNT-1:0] read_port_enable;
    // High when the output register is clocked, low for flow-through
    logic [emr_pkg::PORT_COUNT-1:0] output_clock;
    logic [emr_pkg::PORT_COUNT-1:0][emr_pkg::ADDR_W-1:0] address;
    logic [emr_pkg::PORT_COUNT-1:0][emr_pkg::DATA_W-1:0] data_in;
    logic [emr_pkg::PORT_COUNT-1:0][emr_pkg::PAR_W-1:0] parity_in;
    logic [emr_pkg::PORT_COUNT-1:0][emr_pkg::DATA_W-1:0] data_out;
    logic [emr_pkg::PORT_COUNT-1:0][emr_pkg::PAR_W-1:0] parity_out;
    // Buffer requests and state
    logic fifo_aclr;
    logic fifo_sclr;
    logic write_request;
    logic [emr_pkg::FIFO_WIDTH-1:0] fifo_data;
    logic read_request;
    logic [emr_pkg::FIFO_WIDTH-1:0] fifo_q;
    logic full;
    logic empty;
    logic [emr_pkg::COUNT_W-1:0] used_word_count;

    // Memory block end
    modport device (
        input wide_mode, clock_enable_n, write_port_enable, output_enable,
        input read_port_enable, output_clock, address, data_in, parity_in,
        output data_out, parity_out,
        input fifo_aclr, fifo_sclr, write_request, fifo_data, read_request,
        output fifo_q, full, empty, used_word_count
    );

    // User logic end
    modport user (
        output wide_mode, clock_enable_n, write_port_enable, output_enable,
        output read_port_enable, output_clock, address, data_in, parity_in,
        input data_out, parity_out,
        output fifo_aclr, fifo_sclr, write_request, fifo_data, read_request,
        input fifo_q, full, empty, used_word_count
    );

endinterface
`default_nettype wire

// ===== emr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Single clock buffer with registered read word and honest flags
module emr_fifo #(
    parameter int WIDTH = emr_pkg::FIFO_WIDTH,
    parameter int DEPTH = emr_pkg::FIFO_DEPTH
) (
    // Clock and clears
    input wire logic clk,
    input wire logic aclr,
    input wire logic sclr,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill state
    output logic full,
    output logic empty,
    output logic [$clog2(DEPTH+1)-1:0] used_word_count
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] COUNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] COUNT_NONE = '0;

    // Word store, depth must be a power of two so pointers wrap
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    wire logic wr_ok;
    wire logic rd_ok;
    wire logic [CW-1:0] next_count;

    // Full drops writes, empty drops reads, even when both arrive
    assign wr_ok = in_valid & ~full;
    assign rd_ok = out_ready & ~empty;
    assign next_count = CW'(used_word_count + CW'(wr_ok) - CW'(rd_ok));
    // Handshake view of the flags
    assign in_ready = ~full;
    assign out_valid = ~empty;

    // Store write, no reset needed for contents
    always_ff @(posedge clk) begin
        if (wr_ok) begin
            store[wr_ptr] <= in_data;
        end
    end

    // Pointers, count, flags and read word; either clear empties it
    always_ff @(posedge clk or posedge aclr) begin
        if (aclr) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            used_word_count <= COUNT_NONE;
            full <= 1'b0;
            empty <= 1'b1;
            out_data <= '0;
        end else if (sclr) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            used_word_count <= COUNT_NONE;
            full <= 1'b0;
            empty <= 1'b1;
            out_data <= '0;
        end else begin
            // Oldest word moves to the output only on a taken read
            if (rd_ok) begin
                out_data <= store[rd_ptr];
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (wr_ok) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            used_word_count <= next_count;
            full <= (next_count == COUNT_FULL);
            empty <= (next_count == COUNT_NONE);
        end
    end

endmodule
`default_nettype wire

// ===== emr_block_end.sv
`timescale 1ns/1ps
`default_nettype none
module emr_block_end (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Link to the user logic
    emr_link_if.device LINK,
    // Status
    output logic WRITE_COLLISION
);
    localparam int NP = emr_pkg::PORT_COUNT;
    localparam int BW = emr_pkg::BYTE_W;
    localparam int PP = emr_pkg::PARITY_POS;

    // Cell index of one byte lane; wide words take two neighbouring cells
    function automatic logic [emr_pkg::ADDR_W-1:0] cell_of(
        input logic wide,
        input logic [emr_pkg::ADDR_W-1:0] addr,
        input logic lane
    );
        logic [emr_pkg::ADDR_W-1:0] idx;
        idx = addr;
        if (wide) begin
            idx = {addr[emr_pkg::WIDE_ADDR_W-1:0], lane};
        end
        return idx;
    endfunction

    // Storage: 512 cells of 9 bits, data byte low and parity on top
    logic [emr_pkg::CELL_W-1:0] cells [0:emr_pkg::CELL_COUNT-1];

    // Per port decode results
    wire logic [NP-1:0] write_go;
    wire logic [NP-1:0] read_go;
    wire logic [NP-1:0][emr_pkg::ADDR_W-1:0] lo_cell;
    wire logic [NP-1:0][emr_pkg::ADDR_W-1:0] hi_cell;
    wire logic [NP-1:0][emr_pkg::CELL_W-1:0] lo_word;
    wire logic [NP-1:0][emr_pkg::CELL_W-1:0] hi_word;
    wire logic [NP-1:0][emr_pkg::DATA_W-1:0] flow_data;
    wire logic [NP-1:0][emr_pkg::PAR_W-1:0] flow_par;
    wire logic same_cell;

    // Output registers, one per port
    logic [NP-1:0][emr_pkg::DATA_W-1:0] held_data;
    logic [NP-1:0][emr_pkg::PAR_W-1:0] held_par;

    // The two ports are built from one description, so they match
    generate
        for (genvar p = 0; p < NP; p++) begin : g_port
            // Port stays idle unless its clock enable is low
            assign write_go[p] = ~LINK.clock_enable_n[p]
                & LINK.write_port_enable[p] & LINK.output_enable[p];
            // Reads need write enable low and the read enable high
            assign read_go[p] = ~LINK.clock_enable_n[p]
                & ~LINK.write_port_enable[p]
                & LINK.read_port_enable[p];
            // Lane addressing for the chosen geometry
            assign lo_cell[p] = cell_of(LINK.wide_mode, LINK.address[p], 1'b0);
            assign hi_cell[p] = cell_of(LINK.wide_mode, LINK.address[p], 1'b1);
            assign lo_word[p] = cells[lo_cell[p]];
            assign hi_word[p] = cells[hi_cell[p]];
            // Narrow mode shows one byte and one parity bit, upper bits zero
            assign flow_data[p] = LINK.wide_mode ?
                {hi_word[p][BW-1:0], lo_word[p][BW-1:0]} :
                {{BW{1'b0}}, lo_word[p][BW-1:0]};
            assign flow_par[p] = LINK.wide_mode ?
                {hi_word[p][PP], lo_word[p][PP]} :
                {1'b0, lo_word[p][PP]};
            // Clocked output shows the register, else the array directly
            assign LINK.data_out[p] = LINK.output_clock[p] ?
                held_data[p] : flow_data[p];
            assign LINK.parity_out[p] = LINK.output_clock[p] ?
                held_par[p] : flow_par[p];
        end
    endgenerate

    // Both ports writing the same low cell in one edge
    assign same_cell = (&write_go) & (lo_cell[0] == lo_cell[1]);

    // Array writes on the rising edge only; port 1 wins a clash
    // A true cell would be undefined here, a fixed winner keeps tests stable
    always_ff @(posedge REF_CLK) begin
        for (int p = 0; p < NP; p++) begin
            if (write_go[p]) begin
                cells[lo_cell[p]] <= {LINK.parity_in[p][0],
                    LINK.data_in[p][BW-1:0]};
                if (LINK.wide_mode) begin
                    cells[hi_cell[p]] <= {LINK.parity_in[p][1],
                        LINK.data_in[p][emr_pkg::DATA_W-1:BW]};
                end
            end
        end
    end

    // Output registers load on an enabled read edge and hold otherwise
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            held_data <= {NP{emr_pkg::DATA_RESET}};
            held_par <= {NP{emr_pkg::PAR_RESET}};
        end else begin
            for (int p = 0; p < NP; p++) begin
                if (read_go[p]) begin
                    held_data[p] <= flow_data[p];
                    held_par[p] <= flow_par[p];
                end
            end
        end
    end

    // Collision flag, registered on the clashing edge itself
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            WRITE_COLLISION <= 1'b0;
        end else begin
            WRITE_COLLISION <= same_cell;
        end
    end

    // Buffer clear: block reset joins the user's synchronous clear
    wire logic fifo_clear;
    assign fifo_clear = LINK.fifo_sclr | RST;

    // Handshake view left open; the flags carry the same facts
    // Buffer on the block's single clock
    emr_fifo #(
        .WIDTH(emr_pkg::FIFO_WIDTH),
        .DEPTH(emr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(REF_CLK),
        .aclr(LINK.fifo_aclr),
        .sclr(fifo_clear),
        .in_valid(LINK.write_request),
        .in_ready(),
        .in_data(LINK.fifo_data),
        .out_valid(),
        .out_ready(LINK.read_request),
        .out_data(LINK.fifo_q),
        .full(LINK.full),
        .empty(LINK.empty),
        .used_word_count(LINK.used_word_count)
    );

endmodule
`default_nettype wire

// ===== emr_user_end.sv
`timescale 1ns/1ps
`default_nettype none
// User logic beside the memory: drives commands, makes and checks parity
module emr_user_end (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Link to the memory block
    emr_link_if.user LINK,
    // Geometry and output mode
    input wire logic WIDE,
    input wire logic [1:0] REG_OUT,
    // Memory command
    input wire logic CMD_VALID,
    input wire logic CMD_PORT,
    input wire logic CMD_WRITE,
    input wire logic [emr_pkg::ADDR_W-1:0] CMD_ADDR,
    input wire logic [emr_pkg::DATA_W-1:0] CMD_DATA,
    // Memory results
    output logic [emr_pkg::DATA_W-1:0] RD_DATA0,
    output logic [emr_pkg::DATA_W-1:0] RD_DATA1,
    output logic [1:0] PARITY_ERROR,
    // Buffer command
    input wire logic FIFO_PUSH,
    input wire logic [emr_pkg::DATA_W-1:0] FIFO_DATA,
    input wire logic FIFO_POP,
    input wire logic FIFO_CLEAR,
    // Buffer results
    output logic FIFO_PUSH_READY,
    output logic [emr_pkg::DATA_W-1:0] FIFO_Q,
    output logic FIFO_PARITY_ERROR,
    output logic FIFO_FULL,
    output logic FIFO_EMPTY,
    output logic [emr_pkg::COUNT_W-1:0] FIFO_LEVEL
);
    localparam int BW = emr_pkg::BYTE_W;
    localparam int DW = emr_pkg::DATA_W;

    // Even parity, one bit per byte
    function automatic logic [emr_pkg::PAR_W-1:0] byte_parity(
        input logic [emr_pkg::DATA_W-1:0] d
    );
        return {^d[DW-1:BW], ^d[BW-1:0]};
    endfunction

    // Parity seen on the link
    wire logic [emr_pkg::PAR_W-1:0] fifo_par_seen;
    wire logic [1:0] mem_par_bad;
    assign fifo_par_seen = LINK.fifo_q[emr_pkg::FIFO_WIDTH-1:DW];
    assign mem_par_bad[0] = byte_parity(LINK.data_out[0]) != LINK.parity_out[0];
    assign mem_par_bad[1] = byte_parity(LINK.data_out[1]) != LINK.parity_out[1];

    // Command to the link; clock is REF_CLK on both ends, always present
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            LINK.clock_enable_n <= {2{emr_pkg::CE_IDLE}};
            LINK.write_port_enable <= 2'h0;
            LINK.output_enable <= 2'h0;
            LINK.read_port_enable <= 2'h0;
            LINK.output_clock <= 2'h0;
            LINK.wide_mode <= 1'b0;
            LINK.address <= '0;
            LINK.data_in <= '0;
            LINK.parity_in <= '0;
        end else begin
            // Only the addressed port gets its clock enabled
            for (int p = 0; p < 2; p++) begin
                LINK.clock_enable_n[p] <= ~(CMD_VALID & (CMD_PORT == p[0]));
                LINK.write_port_enable[p] <= CMD_WRITE;
                LINK.output_enable[p] <= CMD_WRITE;
                LINK.read_port_enable[p] <= ~CMD_WRITE;
                LINK.address[p] <= CMD_ADDR;
                LINK.data_in[p] <= CMD_DATA;
                LINK.parity_in[p] <= byte_parity(CMD_DATA);
            end
            LINK.output_clock <= REG_OUT;
            LINK.wide_mode <= WIDE;
        end
    end

    // Buffer requests; the clear inputs are always driven
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            LINK.fifo_aclr <= 1'b1;
            LINK.fifo_sclr <= 1'b0;
            LINK.write_request <= 1'b0;
            LINK.read_request <= 1'b0;
            LINK.fifo_data <= '0;
        end else begin
            LINK.fifo_aclr <= 1'b0;
            LINK.fifo_sclr <= FIFO_CLEAR;
            // Push is masked off while full; a push in the cycle the buffer fills still reaches it and is dropped there
            LINK.write_request <= FIFO_PUSH & ~LINK.full;
            LINK.read_request <= FIFO_POP;
            LINK.fifo_data <= {byte_parity(FIFO_DATA), FIFO_DATA};
        end
    end

    // Results sampled every cycle
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RD_DATA0 <= emr_pkg::DATA_RESET;
            RD_DATA1 <= emr_pkg::DATA_RESET;
            PARITY_ERROR <= 2'h0;
            FIFO_PUSH_READY <= 1'b0;
            FIFO_Q <= emr_pkg::DATA_RESET;
            FIFO_PARITY_ERROR <= 1'b0;
            FIFO_FULL <= 1'b0;
            FIFO_EMPTY <= 1'b1;
            FIFO_LEVEL <= '0;
        end else begin
            RD_DATA0 <= LINK.data_out[0];
            RD_DATA1 <= LINK.data_out[1];
            PARITY_ERROR <= mem_par_bad;
            FIFO_PUSH_READY <= ~LINK.full;
            FIFO_Q <= LINK.fifo_q[DW-1:0];
            FIFO_PARITY_ERROR <= byte_parity(LINK.fifo_q[DW-1:0]) != fifo_par_seen;
            FIFO_FULL <= LINK.full;
            FIFO_EMPTY <= LINK.empty;
            FIFO_LEVEL <= LINK.used_word_count;
        end
    end

endmodule
`default_nettype wire

// ===== emr_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Checks on the link between the memory block and the user logic
module emr_link_asserts (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Buffer side of the link
    input wire logic fifo_aclr,
    input wire logic fifo_sclr,
    input wire logic write_request,
    input wire logic read_request,
    input wire logic [emr_pkg::FIFO_WIDTH-1:0] fifo_q,
    input wire logic full,
    input wire logic empty,
    input wire logic [emr_pkg::COUNT_W-1:0] used_word_count,
    // Memory port side of the link
    input wire logic [emr_pkg::PORT_COUNT-1:0] clock_enable_n,
    input wire logic [emr_pkg::PORT_COUNT-1:0] output_clock,
    input wire logic [emr_pkg::PORT_COUNT-1:0][emr_pkg::DATA_W-1:0] data_out
);
    // Async clear can land mid-cycle, so it aborts checks in flight
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST || fifo_aclr);

    // Lone requests with no sync clear beside them
    sequence s_push_only;
        write_request && !read_request && !fifo_sclr;
    endsequence
    sequence s_pop_only;
        read_request && !write_request && !fifo_sclr;
    endsequence
    // Port 0 stopped for one edge with its output register in use at that edge and the next
    sequence s_port0_idle;
        clock_enable_n[0] && output_clock[0] ##1 output_clock[0];
    endsequence

    a_full_flag_level:
        assert property (full == (used_word_count == 6'h20))
        else $error("full flag disagrees with word count");
    a_empty_flag_level:
        assert property (empty == (used_word_count == 6'h00))
        else $error("empty flag disagrees with word count");
    a_full_drops_write:
        assert property (full ##0 s_push_only |=> $stable(used_word_count))
        else $error("write taken while full");
    a_empty_drops_read:
        assert property (empty ##0 s_pop_only |=> $stable(fifo_q))
        else $error("read taken while empty");
    a_push_counts_up:
        assert property (!full ##0 s_push_only
        |=> used_word_count == $past(used_word_count) + 6'h01)
        else $error("write did not add one word");
    a_pop_counts_down:
        assert property (!empty ##0 s_pop_only
        |=> used_word_count == $past(used_word_count) - 6'h01)
        else $error("read did not remove one word");
    a_both_keep_count:
        assert property (write_request && read_request && !full && !empty
        && !fifo_sclr |=> $stable(used_word_count))
        else $error("read with write changed the count");
    a_full_both_read:
        assert property (full && write_request && read_request && !fifo_sclr
        |=> used_word_count == 6'h1f)
        else $error("full buffer did not read and drop the write");
    a_idle_no_change:
        assert property (!write_request && !read_request && !fifo_sclr
        |=> $stable(used_word_count) && $stable(fifo_q))
        else $error("buffer changed without a request");
    a_sync_clear_empty:
        assert property (fifo_sclr
        |=> empty && !full && used_word_count == 6'h00)
        else $error("sync clear did not empty the buffer");
    a_ce_holds_out:
        assert property (s_port0_idle |-> $stable(data_out[0][7:0]))
        else $error("stopped port changed its output register");
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Counts every comparison and reports each miss at once
`define EMR_CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
    // Clock, reset and bookkeeping
    logic ref_clk;
    logic rst;
    int err_count;
    int checks_done;
    int cycles;
    logic [15:0] q;
    // Memory command inputs
    logic wide;
    logic [1:0] reg_out;
    logic cmd_valid;
    logic cmd_port;
    logic cmd_write;
    logic [8:0] cmd_addr;
    logic [15:0] cmd_data;
    // Buffer command inputs
    logic fifo_push;
    logic [15:0] fifo_data;
    logic fifo_pop;
    logic fifo_clear;
    // Results from the user end, and the collision flag from the block end
    wire logic [15:0] rd_data0;
    wire logic [15:0] rd_data1;
    wire logic [1:0] parity_error;
    wire logic fifo_push_ready;
    wire logic [15:0] fifo_q;
    wire logic fifo_parity_error;
    wire logic fifo_full;
    wire logic fifo_empty;
    wire logic [5:0] fifo_level;
    wire logic write_collision;

    // The two ends face each other over one link
    emr_link_if link ();
    emr_block_end u_emr_block_end (.REF_CLK(ref_clk), .RST(rst), .LINK(link),
        .WRITE_COLLISION(write_collision));
    emr_user_end u_emr_user_end (.REF_CLK(ref_clk), .RST(rst), .LINK(link), .WIDE(wide),
        .REG_OUT(reg_out), .CMD_VALID(cmd_valid), .CMD_PORT(cmd_port), .CMD_WRITE(cmd_write),
        .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .RD_DATA0(rd_data0), .RD_DATA1(rd_data1),
        .PARITY_ERROR(parity_error), .FIFO_PUSH(fifo_push), .FIFO_DATA(fifo_data),
        .FIFO_POP(fifo_pop), .FIFO_CLEAR(fifo_clear), .FIFO_PUSH_READY(fifo_push_ready),
        .FIFO_Q(fifo_q), .FIFO_PARITY_ERROR(fifo_parity_error), .FIFO_FULL(fifo_full),
        .FIFO_EMPTY(fifo_empty), .FIFO_LEVEL(fifo_level));
    // Checker watches the link itself
    emr_link_asserts u_emr_link_asserts (.REF_CLK(ref_clk), .RST(rst),
        .fifo_aclr(link.fifo_aclr), .fifo_sclr(link.fifo_sclr),
        .write_request(link.write_request), .read_request(link.read_request),
        .fifo_q(link.fifo_q), .full(link.full), .empty(link.empty),
        .used_word_count(link.used_word_count), .clock_enable_n(link.clock_enable_n),
        .output_clock(link.output_clock), .data_out(link.data_out));

    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    // Verdict and end of run
    task automatic results();
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Let n edges pass, then step off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // One memory command, held for exactly one edge
    task automatic cmd(input logic port, input logic wr, input logic [8:0] addr,
                       input logic [15:0] data);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_port <= port;
        cmd_write <= wr;
        cmd_addr <= addr;
        cmd_data <= data;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
    endtask

    // Read and wait out the registered path; parity must agree
    task automatic rd(input logic port, input logic [8:0] addr, output logic [15:0] data);
        cmd(port, 1'b0, addr, 16'h0000);
        settle(4);
        data = port ? rd_data1 : rd_data0;
        `EMR_CHECK(parity_error, 2'h0)
    endtask

    // One buffer request pair, then wait for the user end outputs
    task automatic fifo_op(input logic push, input logic pop, input logic [15:0] d);
        @(posedge ref_clk);
        fifo_push <= push;
        fifo_pop <= pop;
        fifo_data <= d;
        @(posedge ref_clk);
        fifo_push <= 1'b0;
        fifo_pop <= 1'b0;
        settle(3);
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        wide = 1'b1;
        reg_out = 2'h3;
        cmd_valid = 1'b0;
        cmd_port = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 9'h000;
        cmd_data = 16'h0000;
        fifo_push = 1'b0;
        fifo_data = 16'h0000;
        fifo_pop = 1'b0;
        fifo_clear = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        settle(3);
        // Wide, registered: write on port 0, read back on either port
        cmd(1'b0, 1'b1, 9'h005, 16'h1234);
        cmd(1'b0, 1'b1, 9'h0ff, 16'hbeef);
        rd(1'b0, 9'h005, q);
        `EMR_CHECK(q, 16'h1234)
        rd(1'b1, 9'h0ff, q);
        `EMR_CHECK(q, 16'hbeef)
        // Port 1 register holds while port 0 rewrites its cell
        cmd(1'b0, 1'b1, 9'h0ff, 16'h7e57);
        settle(3);
        `EMR_CHECK(rd_data1, 16'hbeef)
        rd(1'b1, 9'h0ff, q);
        `EMR_CHECK(q, 16'h7e57)
        // Narrow view: low byte sits in the even cell
        @(posedge ref_clk);
        wide <= 1'b0;
        rd(1'b0, 9'h00a, q);
        `EMR_CHECK(q, 16'h0034)
        rd(1'b1, 9'h00b, q);
        `EMR_CHECK(q, 16'h0012)
        cmd(1'b1, 1'b1, 9'h1fe, 16'h3ca5);
        rd(1'b0, 9'h1fe, q);
        `EMR_CHECK(q, 16'h00a5)
        // Flow-through output follows the array with no read edge
        @(posedge ref_clk);
        wide <= 1'b1;
        reg_out <= 2'h0;
        rd(1'b0, 9'h005, q);
        `EMR_CHECK(q, 16'h1234)
        cmd(1'b1, 1'b1, 9'h005, 16'h5678);
        settle(3);
        `EMR_CHECK(rd_data0, 16'h5678)
        // Fill past the top: the surplus pushes are dropped
        @(posedge ref_clk);
        fifo_push <= 1'b1;
        for (int i = 0; i < 36; i++) begin
            fifo_data <= 16'h0100 + 16'(i);
            @(posedge ref_clk);
        end
        fifo_push <= 1'b0;
        settle(3);
        `EMR_CHECK(fifo_level, 6'h20)
        `EMR_CHECK(fifo_full, 1'b1)
        `EMR_CHECK(fifo_push_ready, 1'b0)
        // Read with write while full: oldest out, write lost
        fifo_op(1'b1, 1'b1, 16'hdead);
        `EMR_CHECK(fifo_q, 16'h0100)
        `EMR_CHECK(fifo_level, 6'h1f)
        // Drain in arrival order
        for (int i = 1; i < 32; i++) begin
            fifo_op(1'b0, 1'b1, 16'h0000);
            `EMR_CHECK(fifo_q, 16'h0100 + 16'(i))
        end
        `EMR_CHECK(fifo_empty, 1'b1)
        `EMR_CHECK(fifo_level, 6'h00)
        // Read while empty changes nothing
        fifo_op(1'b0, 1'b1, 16'h0000);
        `EMR_CHECK(fifo_q, 16'h011f)
        // Both while empty: write kept, read lost
        fifo_op(1'b1, 1'b1, 16'h4242);
        `EMR_CHECK(fifo_q, 16'h011f)
        `EMR_CHECK(fifo_level, 6'h01)
        // Both with one word held: one in, one out
        fifo_op(1'b1, 1'b1, 16'h9999);
        `EMR_CHECK(fifo_q, 16'h4242)
        `EMR_CHECK(fifo_level, 6'h01)
        // Clear empties the buffer and its read word
        @(posedge ref_clk);
        fifo_clear <= 1'b1;
        @(posedge ref_clk);
        fifo_clear <= 1'b0;
        settle(3);
        `EMR_CHECK(fifo_empty, 1'b1)
        `EMR_CHECK(fifo_level, 6'h00)
        `EMR_CHECK(fifo_q, 16'h0000)
        `EMR_CHECK(fifo_parity_error, 1'b0)
        `EMR_CHECK(write_collision, 1'b0)
        results();
    end
endmodule
`default_nettype wire
